// >>> hw/wdt_rst_pkg.sv
package wdt_rst_pkg;
  // Reference clock period in picoseconds (200 MHz).
  localparam int CLK_PERIOD_PS = 5000;
  // Least time the device reset stays asserted after its last cause, in ns.
  localparam int RST_HOLD_NS = 100;
  // Least time rounds up to whole cycles.
  localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_W = 8;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(RST_HOLD_CYC);
  localparam logic [HOLD_W-1:0] HOLD_DONE = 8'h00;

  localparam int W16 = 16;
  localparam int W32 = 32;
  localparam int SUB16 = 2;
  localparam logic [W16-1:0] CNT16_RST = 16'h0000;
  localparam logic [W32-1:0] CNT32_RST = 32'h0000_0000;
  localparam logic [W16-1:0] CNT16_ONE = 16'h0001;
  localparam logic [W32-1:0] CNT32_ONE = 32'h0000_0001;

  // Pin sampler lanes and their idle levels.
  localparam int PIN_N = 5;
  localparam int PIN_ILO = 0;
  localparam int PIN_WCO = 1;
  localparam int PIN_XRST_N = 2;
  localparam int PIN_BOD = 3;
  localparam int PIN_HIB = 4;
  localparam logic [PIN_N-1:0] PIN_IDLE = 5'h04;

  // Reset cause record bit positions.
  localparam int CAUSE_W = 8;
  localparam int C_POR = 0;
  localparam int C_BOD = 1;
  localparam int C_EXT = 2;
  localparam int C_WDT = 3;
  localparam int C_MULTI_COUNTER_WATCHDOG = 4;
  localparam int C_SW = 5;
  localparam int C_PROT = 6;
  localparam int C_HIB = 7;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h01;

  typedef enum logic [1:0] {PM_LP, PM_ULP, PM_DEEP_SLEEP, PM_HIBERNATE} power_mode_e;
  typedef enum logic [1:0] {MC_OFF, MC_INT, MC_RESET, MC_INT_RESET} match_mode_e;

  typedef struct packed {
    logic enable;
    logic reset_en;
    logic [W16-1:0] match;
  } basic_cfg_s;

  typedef struct packed {
    logic [SUB16-1:0][1:0] mode16;
    logic [SUB16-1:0][W16-1:0] match16;
    logic en32;
    logic [W32-1:0] match32;
  } mc_cfg_s;
endpackage

// >>> hw/watchdog_and_reset_control.sv
// How it works
// - Basic watchdog is one sixteen-bit free-running up counter.
// - Each multi-counter watchdog has two 16-bit counters, one 32-bit, selectable modes.
// - Every sixteen-bit counter can reset the whole device on match.
// - Every counter can raise an interrupt when it reaches its match value.
// - Basic watchdog counts only ticks of the low-speed internal oscillator.
// - Basic watchdog keeps counting in all four system power modes and wakes from deep sleep and hibernate.
// - Multi-counter watchdogs use the low-frequency clock, internal or crystal source.
// - Multi-counter watchdogs run in low-power through deep sleep, stop in hibernate.
// - An unserviced enabled watchdog that fires resets the device.
// - Power-on reset holds everything reset until the supply is good.
// - Brown-out on the digital supply resets the device.
// - External reset pin is active low; driving it low resets the device.
// - Firmware can request a device reset.
// - Protection fault gives an interrupt or a reset, as configured.
// - Wakeup from hibernate is carried out as a device reset.
// - Power-on, pin and brown-out resets assert asynchronously; every reset source returns logic to known state.
// - Reset causes are recorded in a record that survives device resets.
// - Low-speed internal oscillator runs near 32 kHz in every mode.
`timescale 1ns/1ps
module watchdog_and_reset_control #(
  parameter int NUM_MC = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic low_speed_internal_osc_i,
  input wire logic watch_crystal_osc_i,
  input wire logic low_freq_clock_sel_wco_i,
  input wire logic external_reset_pin_n_i,
  input wire logic brownout_detect_i,
  input wire logic hibernate_wake_i,
  input wire wdt_rst_pkg::power_mode_e power_mode_i,
  input wire wdt_rst_pkg::basic_cfg_s basic_cfg_i,
  input wire logic basic_service_i,
  input wire wdt_rst_pkg::mc_cfg_s [NUM_MC-1:0] mc_cfg_i,
  input wire logic [NUM_MC-1:0][wdt_rst_pkg::SUB16:0] mc_service_i,
  input wire logic sw_reset_req_i,
  input wire logic prot_fault_i,
  input wire logic prot_reset_en_i,
  input wire logic [wdt_rst_pkg::CAUSE_W-1:0] cause_clear_i,
  output logic basic_irq_o,
  output logic [NUM_MC-1:0][wdt_rst_pkg::SUB16:0] mc_irq_o,
  output logic wake_o,
  output logic prot_irq_o,
  output logic device_reset_o,
  output logic [wdt_rst_pkg::CAUSE_W-1:0] reset_cause_o
);
  localparam int S = wdt_rst_pkg::SUB16;

  if (NUM_MC < 1 || NUM_MC > 8) begin : g_bad_num_mc
    $error("NUM_MC must lie between 1 and 8.");
  end

  logic [wdt_rst_pkg::PIN_N-1:0] pin_raw, s1, s2, s3, filt, filt_q;
  logic async_rst_n, ilo_tick, lf_tick, mc_run, ext_low, bod_on, hib_rise;
  logic [wdt_rst_pkg::HOLD_W-1:0] hold_cnt;
  logic int_req, fire_any_mc;
  logic [wdt_rst_pkg::CAUSE_W-1:0] cause_set;

  // Every pin passes three flops; a change counts once stages two and three agree.
  assign pin_raw = {hibernate_wake_i, brownout_detect_i, external_reset_pin_n_i,
                    watch_crystal_osc_i, low_speed_internal_osc_i};
  for (genvar p = 0; p < wdt_rst_pkg::PIN_N; p++) begin : g_pin
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        s1[p] <= wdt_rst_pkg::PIN_IDLE[p];
        s2[p] <= wdt_rst_pkg::PIN_IDLE[p];
        s3[p] <= wdt_rst_pkg::PIN_IDLE[p];
        filt[p] <= wdt_rst_pkg::PIN_IDLE[p];
        filt_q[p] <= wdt_rst_pkg::PIN_IDLE[p];
      end else begin
        s1[p] <= pin_raw[p];
        s2[p] <= s1[p];
        s3[p] <= s2[p];
        filt[p] <= (s2[p] == s3[p]) ? s3[p] : filt[p];
        filt_q[p] <= filt[p];
      end
    end
  end

  // Oscillator rising edges become one-cycle ticks on the system clock.
  assign ilo_tick = filt[wdt_rst_pkg::PIN_ILO] & ~filt_q[wdt_rst_pkg::PIN_ILO];
  assign lf_tick = low_freq_clock_sel_wco_i ? (filt[wdt_rst_pkg::PIN_WCO] & ~filt_q[wdt_rst_pkg::PIN_WCO])
                                   : ilo_tick;
  // Hibernate has no multi-counter operation, so their ticks are gated off there.
  assign mc_run = lf_tick & (power_mode_i != wdt_rst_pkg::PM_HIBERNATE);
  assign ext_low = ~filt[wdt_rst_pkg::PIN_XRST_N];
  assign bod_on = filt[wdt_rst_pkg::PIN_BOD];
  assign hib_rise = filt[wdt_rst_pkg::PIN_HIB] & ~filt_q[wdt_rst_pkg::PIN_HIB];

  // Power-on, pin and brown-out reset assert without a clock; release is synchronous.
  assign async_rst_n = rst_n_i & external_reset_pin_n_i & ~brownout_detect_i;

  // Basic watchdog counter, service latch and its match events.
  logic [wdt_rst_pkg::W16-1:0] basic_cnt;
  logic basic_svc, basic_ev, basic_fire, basic_wake_rst;
  assign basic_ev = ilo_tick & basic_cfg_i.enable & (basic_cnt == basic_cfg_i.match);
  always_ff @(posedge clk_sys_i or negedge async_rst_n) begin
    if (!async_rst_n) begin
      basic_cnt <= wdt_rst_pkg::CNT16_RST;
    end else if (device_reset_o) begin
      basic_cnt <= wdt_rst_pkg::CNT16_RST;
    end else if (ilo_tick && basic_svc) begin
      basic_cnt <= wdt_rst_pkg::CNT16_RST;
    end else if (ilo_tick && basic_cfg_i.enable) begin
      basic_cnt <= basic_cnt + wdt_rst_pkg::CNT16_ONE;
    end
  end

  // A service request waits for the next oscillator tick; a new request wins the clear.
  always_ff @(posedge clk_sys_i or negedge async_rst_n) begin
    if (!async_rst_n) begin
      basic_svc <= 1'b0;
    end else if (basic_service_i) begin
      basic_svc <= 1'b1;
    end else if (ilo_tick || device_reset_o) begin
      basic_svc <= 1'b0;
    end
  end

  // Firing registers: reset on match, and hibernate wakeup turns into a reset.
  always_ff @(posedge clk_sys_i or negedge async_rst_n) begin
    if (!async_rst_n) begin
      basic_fire <= 1'b0;
      basic_wake_rst <= 1'b0;
    end else begin
      basic_fire <= basic_ev & basic_cfg_i.reset_en & ~basic_svc & ~device_reset_o;
      basic_wake_rst <= (basic_ev & (power_mode_i == wdt_rst_pkg::PM_HIBERNATE)) | hib_rise;
    end
  end

  // Multi-counter watchdogs: two periodic 16-bit counters and one 32-bit counter each.
  logic [NUM_MC-1:0][S:0] mc_ev, mc_fire_ev;
  for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
    logic [wdt_rst_pkg::W32-1:0] cnt32;
    logic [S:0] svc;
    for (genvar j = 0; j < S; j++) begin : g_sub
      logic [wdt_rst_pkg::W16-1:0] cnt;
      wdt_rst_pkg::match_mode_e mode;
      assign mode = wdt_rst_pkg::match_mode_e'(mc_cfg_i[m].mode16[j]);
      assign mc_ev[m][j] = mc_run & (mode != wdt_rst_pkg::MC_OFF)
                           & (cnt == mc_cfg_i[m].match16[j]);
      assign mc_fire_ev[m][j] = mc_ev[m][j] & ~svc[j]
                                & ((mode == wdt_rst_pkg::MC_RESET) | (mode == wdt_rst_pkg::MC_INT_RESET));
      always_ff @(posedge clk_sys_i or negedge async_rst_n) begin
        if (!async_rst_n) begin
          cnt <= wdt_rst_pkg::CNT16_RST;
        end else if (device_reset_o) begin
          cnt <= wdt_rst_pkg::CNT16_RST;
        end else if (mc_run && (svc[j] || mc_ev[m][j])) begin
          cnt <= wdt_rst_pkg::CNT16_RST;
        end else if (mc_run && mode != wdt_rst_pkg::MC_OFF) begin
          cnt <= cnt + wdt_rst_pkg::CNT16_ONE;
        end
      end
    end
    // The wide counter only interrupts; it never resets the device.
    assign mc_ev[m][S] = mc_run & mc_cfg_i[m].en32 & (cnt32 == mc_cfg_i[m].match32);
    assign mc_fire_ev[m][S] = 1'b0;
    always_ff @(posedge clk_sys_i or negedge async_rst_n) begin
      if (!async_rst_n) begin
        cnt32 <= wdt_rst_pkg::CNT32_RST;
      end else if (device_reset_o) begin
        cnt32 <= wdt_rst_pkg::CNT32_RST;
      end else if (mc_run && (svc[S] || mc_ev[m][S])) begin
        cnt32 <= wdt_rst_pkg::CNT32_RST;
      end else if (mc_run && mc_cfg_i[m].en32) begin
        cnt32 <= cnt32 + wdt_rst_pkg::CNT32_ONE;
      end
    end
    // Service latches of this instance; a fresh request wins the clear.
    always_ff @(posedge clk_sys_i or negedge async_rst_n) begin
      if (!async_rst_n) begin
        svc <= '0;
      end else begin
        svc <= mc_service_i[m] | (svc & {(S + 1){~(mc_run | device_reset_o)}});
      end
    end
  end

  // Interrupt and wake pulses, registered so every output leaves a flop.
  logic [NUM_MC-1:0][S:0] mc_int_en;
  logic mc_fire;
  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      for (int j = 0; j <= S; j++) begin
        mc_int_en[m][j] = (j == S) ? 1'b1
                          : ((mc_cfg_i[m].mode16[j] == wdt_rst_pkg::MC_INT)
                             | (mc_cfg_i[m].mode16[j] == wdt_rst_pkg::MC_INT_RESET));
      end
    end
  end
  always_ff @(posedge clk_sys_i or negedge async_rst_n) begin
    if (!async_rst_n) begin
      basic_irq_o <= 1'b0;
      mc_irq_o <= '0;
      wake_o <= 1'b0;
      prot_irq_o <= 1'b0;
      mc_fire <= 1'b0;
    end else begin
      basic_irq_o <= basic_ev;
      mc_irq_o <= mc_ev & mc_int_en;
      wake_o <= (power_mode_i == wdt_rst_pkg::PM_DEEP_SLEEP || power_mode_i == wdt_rst_pkg::PM_HIBERNATE)
                & (basic_ev | (|(mc_ev & mc_int_en)));
      prot_irq_o <= prot_fault_i & ~prot_reset_en_i;
      mc_fire <= (|mc_fire_ev) & ~device_reset_o;
    end
  end
  assign fire_any_mc = mc_fire;

  // Clocked reset requests restart the hold counter.
  assign int_req = basic_fire | fire_any_mc | basic_wake_rst | sw_reset_req_i
                   | (prot_fault_i & prot_reset_en_i);

  // Reset stretcher: asserted asynchronously, released after the hold time.
  always_ff @(posedge clk_sys_i or negedge async_rst_n) begin
    if (!async_rst_n) begin
      hold_cnt <= wdt_rst_pkg::HOLD_LOAD;
      device_reset_o <= 1'b1;
    end else begin
      if (int_req) begin
        hold_cnt <= wdt_rst_pkg::HOLD_LOAD;
      end else if (hold_cnt != wdt_rst_pkg::HOLD_DONE) begin
        hold_cnt <= hold_cnt - 8'h01;
      end
      device_reset_o <= int_req | (hold_cnt != wdt_rst_pkg::HOLD_DONE);
    end
  end

  // Cause record sits on power-on reset only, so device resets leave it alone.
  always_comb begin
    cause_set = '0;
    cause_set[wdt_rst_pkg::C_BOD] = bod_on;
    cause_set[wdt_rst_pkg::C_EXT] = ext_low;
    cause_set[wdt_rst_pkg::C_WDT] = basic_fire;
    cause_set[wdt_rst_pkg::C_MULTI_COUNTER_WATCHDOG] = fire_any_mc;
    cause_set[wdt_rst_pkg::C_SW] = sw_reset_req_i;
    cause_set[wdt_rst_pkg::C_PROT] = prot_fault_i & prot_reset_en_i;
    cause_set[wdt_rst_pkg::C_HIB] = basic_wake_rst;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_cause_o <= wdt_rst_pkg::CAUSE_RST;
    end else begin
      reset_cause_o <= (reset_cause_o & ~cause_clear_i) | cause_set;
    end
  end

  sequence s_held;
    device_reset_o [*8];
  endsequence

  a_basic_wrap16: assert property (@(posedge clk_sys_i) disable iff (!async_rst_n)
    (ilo_tick && basic_cfg_i.enable && !basic_svc && !device_reset_o && basic_cnt == 16'hFFFF)
    |=> basic_cnt == wdt_rst_pkg::CNT16_RST) else $error("Basic counter did not wrap at 16 bits.");
  a_mc_periodic: assert property (@(posedge clk_sys_i) disable iff (!async_rst_n)
    (mc_ev[0][0] && !device_reset_o) |=> g_mc[0].g_sub[0].cnt == wdt_rst_pkg::CNT16_RST)
    else $error("Sixteen-bit counter not restarted on match.");
  a_wdt_reset_hold: assert property (@(posedge clk_sys_i) disable iff (!async_rst_n)
    basic_fire |=> s_held) else $error("Watchdog fire did not hold device reset.");
  a_basic_irq: assert property (@(posedge clk_sys_i) disable iff (!async_rst_n)
    basic_ev |=> basic_irq_o) else $error("Basic match gave no interrupt.");
  a_mc_hib_stop: assert property (@(posedge clk_sys_i) disable iff (!async_rst_n)
    (power_mode_i == wdt_rst_pkg::PM_HIBERNATE && !device_reset_o) |=> $stable(g_mc[0].cnt32))
    else $error("Multi-counter ran in hibernate.");
  a_sw_reset: assert property (@(posedge clk_sys_i) disable iff (!async_rst_n)
    sw_reset_req_i |=> device_reset_o ##1 device_reset_o) else $error("Software reset not taken.");
  a_prot_route: assert property (@(posedge clk_sys_i) disable iff (!async_rst_n)
    prot_fault_i |=> (prot_irq_o != $past(prot_reset_en_i)) && (device_reset_o || !$past(prot_reset_en_i)))
    else $error("Protection fault routed wrongly.");
  a_cause_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (reset_cause_o[wdt_rst_pkg::C_SW] && !cause_clear_i[wdt_rst_pkg::C_SW]) |=> reset_cause_o[wdt_rst_pkg::C_SW])
    else $error("Cause flag lost without a clear.");
  a_cause_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sw_reset_req_i |=> reset_cause_o[wdt_rst_pkg::C_SW]) else $error("Software reset not recorded.");
endmodule

// >>> tb/test_watchdog_and_reset_control.sv
`timescale 1ns/1ps
module test_watchdog_and_reset_control;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic osc = 1'b0;
  logic watch_crystal_osc = 1'b0;
  logic sel_wco = 1'b0;
  logic ext_n = 1'b1;
  logic brownout_detect = 1'b0;
  logic hib = 1'b0;
  logic svc = 1'b0;
  logic [5:0] msvc = 6'h00;
  logic swr = 1'b0;
  logic pf = 1'b0;
  logic pren = 1'b0;
  logic [7:0] cclr = 8'h00;
  wdt_rst_pkg::power_mode_e pm = wdt_rst_pkg::PM_LP;
  wdt_rst_pkg::basic_cfg_s bcfg = '0;
  wdt_rst_pkg::mc_cfg_s [1:0] mcfg = '0;
  logic basic_irq_o;
  logic [1:0][2:0] mc_irq_o;
  logic wake_o;
  logic prot_irq_o;
  logic device_reset_o;
  logic [7:0] reset_cause_o;
  int n_fail = 0;
  int comparisons = 0;
  int seen_b, seen_m, seen_l, seen_w;

  // Free-running 200 MHz system clock.
  always #2.5 clk_sys_i = ~clk_sys_i;

  watchdog_and_reset_control #(.NUM_MC(2)) i_watchdog_and_reset_control (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .low_speed_internal_osc_i(osc), .watch_crystal_osc_i(watch_crystal_osc),
    .low_freq_clock_sel_wco_i(sel_wco), .external_reset_pin_n_i(ext_n), .brownout_detect_i(brownout_detect),
    .hibernate_wake_i(hib), .power_mode_i(pm), .basic_cfg_i(bcfg), .basic_service_i(svc),
    .mc_cfg_i(mcfg), .mc_service_i(msvc), .sw_reset_req_i(swr), .prot_fault_i(pf),
    .prot_reset_en_i(pren), .cause_clear_i(cclr), .basic_irq_o(basic_irq_o), .mc_irq_o(mc_irq_o),
    .wake_o(wake_o), .prot_irq_o(prot_irq_o), .device_reset_o(device_reset_o), .reset_cause_o(reset_cause_o));

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts edges until the device reset drops; the hold must last a known span.
  task automatic release_count(input string what, input int lo, input int hi);
    int n;
    n = 0;
    while (device_reset_o !== 1'b0 && n < 100) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check(what, (n >= lo && n <= hi), 1);
  endtask

  task automatic clear_causes;
    @(posedge clk_sys_i) cclr <= 8'hff;
    @(posedge clk_sys_i) cclr <= 8'h00;
    @(posedge clk_sys_i) #1;
    check("cause cleared", reset_cause_o, 8'h00);
  endtask

  // One slow oscillator tick, 16 cycles high and 15 low, with the outputs watched every cycle.
  task automatic tick(input bit crystal, input bit service);
    logic prev;
    prev = 1'b0;
    @(posedge clk_sys_i);
    svc <= service;
    msvc <= service ? 6'h3f : 6'h00;
    if (crystal) osc <= 1'b0;
    if (crystal) watch_crystal_osc <= 1'b1;
    else osc <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_sys_i);
      svc <= 1'b0;
      msvc <= 6'h00;
      if (i == 15) begin
        osc <= 1'b0;
        watch_crystal_osc <= 1'b0;
      end
      #1;
      if (prev === 1'b1) check("reset after match", device_reset_o, 1);
      prev = basic_irq_o | mc_irq_o[0][0];
      if (basic_irq_o === 1'b1) seen_b++;
      if (mc_irq_o[0][0] === 1'b1) seen_m++;
      if (mc_irq_o[1][2] === 1'b1) seen_l++;
      if (wake_o === 1'b1) seen_w++;
    end
  endtask

  task automatic sw_scenario;
    @(posedge clk_sys_i) swr <= 1'b1;
    @(posedge clk_sys_i) swr <= 1'b0;
    @(posedge clk_sys_i) #1;
    check("sw reset", device_reset_o, 1);
    check("cause after sw", reset_cause_o, 8'h21);
    release_count("sw hold", 20, 20);
    clear_causes();
  endtask

  // Asynchronous sources must assert the reset before any clock edge.
  task automatic async_scenario(input bit brown, input logic [7:0] exp);
    @(posedge clk_sys_i);
    if (brown) brownout_detect <= 1'b1;
    else ext_n <= 1'b0;
    #1;
    check("async reset", device_reset_o, 1);
    repeat (6) @(posedge clk_sys_i);
    #1;
    check("async cause", reset_cause_o, exp);
    @(posedge clk_sys_i);
    brownout_detect <= 1'b0;
    ext_n <= 1'b1;
    release_count("async hold", 21, 26);
    check("cause kept", reset_cause_o, exp);
    clear_causes();
  endtask

  task automatic prot_scenario;
    @(posedge clk_sys_i) pf <= 1'b1;
    @(posedge clk_sys_i) pf <= 1'b0;
    #1;
    check("prot irq", prot_irq_o, 1);
    check("prot no reset", device_reset_o, 0);
    @(posedge clk_sys_i);
    pf <= 1'b1;
    pren <= 1'b1;
    @(posedge clk_sys_i) pf <= 1'b0;
    @(posedge clk_sys_i) #1;
    check("prot reset", device_reset_o, 1);
    check("prot cause", reset_cause_o, 8'h40);
    release_count("prot hold", 20, 20);
    clear_causes();
  endtask

  task automatic hib_scenario;
    int n;
    n = 0;
    @(posedge clk_sys_i) hib <= 1'b1;
    while (device_reset_o !== 1'b1 && n < 20) begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    check("wake reset", device_reset_o, 1);
    check("wake cause", reset_cause_o, 8'h80);
    hib <= 1'b0;
    release_count("wake hold", 20, 26);
    clear_causes();
  endtask

  // Serviced ticks keep the basic counter away from its match; unserviced ticks let it fire.
  task automatic basic_scenario;
    int k;
    @(posedge clk_sys_i) bcfg <= '{enable: 1'b1, reset_en: 1'b1, match: 16'h0003};
    seen_b = 0;
    for (int i = 0; i < 8; i++) tick(1'b0, 1'b1);
    check("serviced no irq", seen_b, 0);
    k = 0;
    while (seen_b == 0 && k < 8) begin
      tick(1'b0, 1'b0);
      k++;
    end
    check("basic match ticks", (k >= 3 && k <= 4), 1);
    check("basic cause", reset_cause_o, 8'h08);
    @(posedge clk_sys_i) bcfg <= '0;
    release_count("basic hold", 0, 30);
    clear_causes();
  endtask

  task automatic mc_scenario;
    int k;
    @(posedge clk_sys_i);
    sel_wco <= 1'b1;
    mcfg[0].mode16[0] <= wdt_rst_pkg::MC_INT_RESET;
    mcfg[0].match16[0] <= 16'h0002;
    mcfg[1].en32 <= 1'b1;
    mcfg[1].match32 <= 32'h0000_0001;
    seen_m = 0;
    seen_l = 0;
    k = 0;
    while (seen_m == 0 && k < 8) begin
      tick(1'b1, 1'b0);
      k++;
    end
    check("mc match ticks", (k >= 2 && k <= 3), 1);
    check("mc 32 irq", (seen_l > 0), 1);
    check("mc cause", reset_cause_o, 8'h10);
    @(posedge clk_sys_i) mcfg[0] <= '0;
    release_count("mc hold", 0, 30);
    clear_causes();
    // Deep sleep turns the wide counter's interrupt into a wakeup; hibernate freezes these counters.
    @(posedge clk_sys_i) pm <= wdt_rst_pkg::PM_DEEP_SLEEP;
    seen_w = 0;
    for (int i = 0; i < 3; i++) tick(1'b1, 1'b0);
    check("deep sleep wake", (seen_w > 0), 1);
    @(posedge clk_sys_i) pm <= wdt_rst_pkg::PM_HIBERNATE;
    seen_l = 0;
    for (int i = 0; i < 4; i++) tick(1'b1, 1'b0);
    check("hibernate frozen", seen_l, 0);
    @(posedge clk_sys_i) pm <= wdt_rst_pkg::PM_LP;
    // A service at every tick keeps the wide counter from ever reaching its match.
    tick(1'b1, 1'b1);
    seen_l = 0;
    for (int i = 0; i < 3; i++) tick(1'b1, 1'b1);
    check("serviced wide counter", seen_l, 0);
  endtask

  // Main sequence: power-on reset, then one task call per reset source.
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    release_count("por hold", 21, 21);
    check("cause after por", reset_cause_o, 8'h01);
    sw_scenario();
    async_scenario(1'b0, 8'h04);
    async_scenario(1'b1, 8'h02);
    prot_scenario();
    hib_scenario();
    basic_scenario();
    mc_scenario();
    give_verdict();
  end

  // Watchdog for the bench itself; the run needs well under a tenth of this span.
  initial begin
    #200_000;
    n_fail++;
    give_verdict();
  end
endmodule
